// file: rtl/ccuif_pkg.sv
// constants, types and decode helpers for the channel control unit interface
package ccuif_pkg;

  // bus widths on both directions: eight data bits plus parity
  localparam int DATA_W = 8;
  localparam int BUS_W  = 9;
  localparam int PAR_POS = 8;

  // depth of the inbound data buffer
  localparam int FIFO_DEPTH = 2;

  // reset synchroniser length
  localparam int RST_STAGES = 2;

  // command byte fields (bit 0 is the least significant bit)
  localparam logic [1:0] CMD_LO2_READ  = 2'h2;
  localparam logic [1:0] CMD_LO2_WRITE = 2'h1;
  localparam logic [1:0] CMD_LO2_CTRL  = 2'h3;
  localparam logic [3:0] CMD_LO4_RDBK  = 4'hC;
  localparam logic [3:0] CMD_LO4_SENSE = 4'h4;
  localparam logic [7:0] CMD_TEST      = 8'h00;

  // status bytes presented on the inbound bus
  localparam logic [7:0] STAT_ACCEPT = 8'h00;
  localparam logic [7:0] STAT_END    = 8'h0C;
  localparam logic [7:0] STAT_CHECK  = 8'h02;

  // values after reset
  localparam logic [8:0] BUS_IN_RST = 9'h100;

  typedef enum logic [2:0] {
    CK_TEST  = 3'b000,
    CK_READ  = 3'b001,
    CK_WRITE = 3'b010,
    CK_CTRL  = 3'b011,
    CK_NOOP  = 3'b100,
    CK_RDBK  = 3'b101,
    CK_SENSE = 3'b110,
    CK_BAD   = 3'b111
  } ccuif_cmd_e;

  // odd parity bit over a data byte
  function automatic logic ccuif_par(input logic [7:0] d);
    ccuif_par = ~(^d);
  endfunction

  // classify a command byte
  function automatic ccuif_cmd_e ccuif_decode(input logic [7:0] c);
    if (c == CMD_TEST)                   ccuif_decode = CK_TEST;
    else if (c[3:0] == CMD_LO4_RDBK)     ccuif_decode = CK_RDBK;
    else if (c[3:0] == CMD_LO4_SENSE)    ccuif_decode = CK_SENSE;
    else if (c[1:0] == CMD_LO2_READ)     ccuif_decode = CK_READ;
    else if (c[1:0] == CMD_LO2_WRITE)    ccuif_decode = CK_WRITE;
    else if (c[1:0] == CMD_LO2_CTRL)     ccuif_decode = (c[7:2] == 6'h00) ? CK_NOOP : CK_CTRL;
    else                                 ccuif_decode = CK_BAD;
  endfunction

endpackage

// file: rtl/ccuif_top.sv
// control unit end of a byte-parallel channel interface with selection chain logic
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - low bits 10 read, 01 write, 11 control
// - low nibble 1100 read-backward, 0100 sense
// - all-zero byte is test-status
// - control with zero modifiers is no-operation
// - sense returns one byte describing unit check
// - unneeded, unaddressed unit forwards select
// - nearer units on chain win selection
// - requesting unit blocks select when address-out is low, starts own selection
// - downstream sees no select during own selection
// - sixteen out, fifteen in, nine-bit buses
// - operational-out low resets and masks interface
// - hold-out fall drops forwarded select at once
// - halt arrives as interface disconnect sequence
// - test-status presents then clears pending status
// - handshakes are edge interlocked
// - raise operational-in when addressed or requesting
// - service tags mark and acknowledge data
module ccuif_top
  import ccuif_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [BUS_W-1:0] bus_out,
  input  wire logic             op_out,
  input  wire logic             hold_out,
  input  wire logic             sel_out,
  input  wire logic             supp_out,
  input  wire logic             addr_out,
  input  wire logic             cmd_out,
  input  wire logic             srv_out,
  output logic [BUS_W-1:0]      bus_in_reg,
  output logic                  op_in_reg,
  output logic                  sel_fwd_reg,
  output logic                  req_in_reg,
  output logic                  addr_in_reg,
  output logic                  sta_in_reg,
  output logic                  srv_in_reg,
  input  wire logic [7:0]       cfg_base,
  input  wire logic [7:0]       cfg_mask,
  input  wire logic [7:0]       svc_addr,
  input  wire logic             need_service,
  input  wire logic             status_event,
  input  wire logic [7:0]       status_byte,
  input  wire logic [7:0]       sense_byte,
  input  wire logic             dev_done,
  input  wire logic [7:0]       rd_data,
  input  wire logic             rd_valid,
  output logic                  rd_ready_reg,
  output logic [7:0]            wr_data_reg,
  output logic                  wr_valid_reg,
  input  wire logic             wr_ready,
  output logic                  cmd_strobe_reg,
  output logic [7:0]            cmd_byte_reg,
  output ccuif_cmd_e            cmd_kind_reg,
  output logic                  par_err_reg
);

  typedef enum logic [3:0] {
    S_IDLE      = 4'b0000,
    S_ADDR_WAIT = 4'b0001,
    S_ADDR_IN   = 4'b0010,
    S_CMD_DROP  = 4'b0011,
    S_STAT      = 4'b0100,
    S_STAT_DROP = 4'b0101,
    S_XFER      = 4'b0110,
    S_DATA      = 4'b0111,
    S_DATA_DROP = 4'b1000,
    S_REL       = 4'b1001
  } ccuif_state_e;

  ccuif_state_e          state_reg;
  logic [RST_STAGES-1:0] rst_sync_reg;
  logic                  rst_sync_n;
  logic                  cui_reg;
  logic                  final_reg;
  logic                  from_pend_reg;
  logic                  stack_reg;
  logic                  stop_reg;
  logic                  sense_sent_reg;
  logic                  addr_out_q;
  logic                  pend_valid_reg;
  logic [7:0]            pend_byte_reg;
  logic [7:0]            fifo_mem [FIFO_DEPTH];
  logic                  fifo_wp_reg;
  logic                  fifo_rp_reg;
  logic [1:0]            fifo_cnt_reg;
  logic [1:0]            fifo_cnt_next;
  logic                  fifo_push;
  logic                  fifo_pop;
  logic                  addr_hit;
  logic                  claim_iss;
  logic                  claim_poll;
  logic                  disc_seen;
  logic                  pend_take;
  logic                  is_read;
  logic                  bus_par_bad;
  logic [7:0]            stat_pick;

  // release of the asynchronous reset through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= '0;
    else
      rst_sync_reg <= {rst_sync_reg[RST_STAGES-2:0], 1'b1};
  end
  assign rst_sync_n = rst_sync_reg[RST_STAGES-1];

  // address block match, selection claims and disconnect detection
  assign addr_hit    = (((bus_out[7:0] ^ cfg_base) & cfg_mask) == 8'h00);
  assign claim_iss   = op_out && sel_out && hold_out && addr_out && addr_hit;
  assign claim_poll  = op_out && sel_out && hold_out && !addr_out && need_service;
  assign disc_seen   = addr_out && !addr_out_q && op_in_reg && !sel_out
                       && (state_reg != S_ADDR_WAIT);
  assign is_read     = (cmd_kind_reg == CK_READ) || (cmd_kind_reg == CK_RDBK);
  assign bus_par_bad = (bus_out[PAR_POS] != ccuif_par(bus_out[7:0]));
  assign pend_take   = (state_reg == S_STAT_DROP) && !srv_out && !cmd_out
                       && from_pend_reg && !stack_reg;
  assign fifo_pop    = (state_reg == S_DATA) && srv_out && is_read;
  assign fifo_push   = rd_valid && rd_ready_reg;
  assign stat_pick   = pend_valid_reg ? pend_byte_reg : STAT_END;

  // edge history of address-out for the disconnect sequence
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      addr_out_q <= 1'b0;
    else
      addr_out_q <= addr_out && op_out;
  end

  // selection chain: forward select unless claiming or connected, purge on hold-out
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sel_fwd_reg <= 1'b0;
      req_in_reg  <= 1'b0;
    end
    else
    begin
      sel_fwd_reg <= op_out && sel_out && hold_out && (state_reg == S_IDLE)
                     && !claim_iss && !claim_poll;
      req_in_reg  <= op_out && need_service && (state_reg == S_IDLE) && !claim_poll;
    end
  end

  // pending status held for the channel, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pend_valid_reg <= 1'b0;
      pend_byte_reg  <= 8'h00;
    end
    else if (status_event)
    begin
      pend_valid_reg <= 1'b1;
      pend_byte_reg  <= status_byte;
    end
    else if (pend_take)
      pend_valid_reg <= 1'b0;
  end

  // two-entry inbound buffer between the device and the channel
  always_comb
  begin
    fifo_cnt_next = fifo_cnt_reg;
    if (fifo_push && !fifo_pop)
      fifo_cnt_next = fifo_cnt_reg + 2'd1;
    else if (fifo_pop && !fifo_push)
      fifo_cnt_next = fifo_cnt_reg - 2'd1;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fifo_wp_reg  <= 1'b0;
      fifo_rp_reg  <= 1'b0;
      fifo_cnt_reg <= 2'd0;
      rd_ready_reg <= 1'b0;
    end
    else
    begin
      if (fifo_push)
        fifo_wp_reg <= ~fifo_wp_reg;
      if (fifo_pop)
        fifo_rp_reg <= ~fifo_rp_reg;
      fifo_cnt_reg <= fifo_cnt_next;
      rd_ready_reg <= (fifo_cnt_next != 2'd2);
    end
  end

  // buffer storage
  always_ff @(posedge sys_clk)
  begin
    if (fifo_push)
      fifo_mem[fifo_wp_reg] <= rd_data;
  end

  // sticky parity error on received bytes, cleared by the interface reset
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      par_err_reg <= 1'b0;
    else if (!op_out)
      par_err_reg <= 1'b0;
    else if (bus_par_bad && ((state_reg == S_IDLE && addr_out && sel_out)  // disconnect has a stale bus
             || (state_reg == S_ADDR_IN && cmd_out)
             || (state_reg == S_DATA && srv_out && !is_read && cmd_kind_reg != CK_SENSE)))
      par_err_reg <= 1'b1;
  end

  // write data handed to the device
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_valid_reg <= 1'b0;
      wr_data_reg  <= 8'h00;
    end
    else if (state_reg == S_DATA && srv_out && !is_read && cmd_kind_reg != CK_SENSE)
    begin
      wr_valid_reg <= 1'b1;
      wr_data_reg  <= bus_out[7:0];
    end
    else if (wr_ready)
      wr_valid_reg <= 1'b0;
  end

  // tag sequencer: selection, command, status and data interlocks
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg      <= S_IDLE;
      op_in_reg      <= 1'b0;
      addr_in_reg    <= 1'b0;
      sta_in_reg     <= 1'b0;
      srv_in_reg     <= 1'b0;
      bus_in_reg     <= BUS_IN_RST;
      cui_reg        <= 1'b0;
      final_reg      <= 1'b0;
      from_pend_reg  <= 1'b0;
      stack_reg      <= 1'b0;
      stop_reg       <= 1'b0;
      sense_sent_reg <= 1'b0;
      cmd_strobe_reg <= 1'b0;
      cmd_byte_reg   <= 8'h00;
      cmd_kind_reg   <= CK_TEST;
    end
    else
    begin
      cmd_strobe_reg <= 1'b0;
      if (!op_out || disc_seen)
      begin
        state_reg   <= S_IDLE;
        op_in_reg   <= 1'b0;
        addr_in_reg <= 1'b0;
        sta_in_reg  <= 1'b0;
        srv_in_reg  <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          S_IDLE:
          begin
            if (claim_iss)
            begin
              op_in_reg <= 1'b1;
              cui_reg   <= 1'b0;
              bus_in_reg <= {ccuif_par(bus_out[7:0]), bus_out[7:0]};
              state_reg <= S_ADDR_WAIT;
            end
            else if (claim_poll)
            begin
              op_in_reg   <= 1'b1;
              addr_in_reg <= 1'b1;
              cui_reg     <= 1'b1;
              bus_in_reg  <= {ccuif_par(svc_addr), svc_addr};
              state_reg   <= S_ADDR_IN;
            end
          end
          S_ADDR_WAIT:
          begin
            if (!addr_out)
            begin
              addr_in_reg <= 1'b1;
              state_reg   <= S_ADDR_IN;
            end
          end
          S_ADDR_IN:
          begin
            if (cmd_out)
            begin
              addr_in_reg <= 1'b0;
              state_reg   <= S_CMD_DROP;
              if (!cui_reg)
              begin
                cmd_byte_reg   <= bus_out[7:0];
                cmd_kind_reg   <= ccuif_decode(bus_out[7:0]);
                cmd_strobe_reg <= 1'b1;
              end
            end
          end
          S_CMD_DROP:
          begin
            if (!cmd_out)
            begin
              sta_in_reg     <= 1'b1;
              sense_sent_reg <= 1'b0;
              stop_reg       <= 1'b0;
              state_reg      <= S_STAT;
              from_pend_reg  <= cui_reg || (cmd_kind_reg == CK_TEST);
              final_reg      <= cui_reg || (cmd_kind_reg == CK_TEST) || (cmd_kind_reg == CK_NOOP)
                                || (cmd_kind_reg == CK_BAD);
              if (cui_reg || cmd_kind_reg == CK_TEST)
                bus_in_reg <= {ccuif_par(stat_pick), stat_pick};
              else if (cmd_kind_reg == CK_NOOP)
                bus_in_reg <= {ccuif_par(STAT_END), STAT_END};
              else if (cmd_kind_reg == CK_BAD)
                bus_in_reg <= {ccuif_par(STAT_CHECK), STAT_CHECK};
              else
                bus_in_reg <= {ccuif_par(STAT_ACCEPT), STAT_ACCEPT};
            end
          end
          S_STAT:
          begin
            if (srv_out || cmd_out)
            begin
              sta_in_reg <= 1'b0;
              stack_reg  <= cmd_out;
              state_reg  <= S_STAT_DROP;
            end
          end
          S_STAT_DROP:
          begin
            if (!srv_out && !cmd_out)
              state_reg <= final_reg ? S_REL : S_XFER;
          end
          S_XFER:
          begin
            if (stop_reg || (cmd_kind_reg == CK_SENSE && sense_sent_reg)
                || (dev_done && (!is_read || fifo_cnt_reg == 2'd0)))
            begin
              sta_in_reg    <= 1'b1;
              final_reg     <= 1'b1;
              from_pend_reg <= 1'b0;
              bus_in_reg    <= {ccuif_par(STAT_END), STAT_END};
              state_reg     <= S_STAT;
            end
            else if (cmd_kind_reg == CK_SENSE)
            begin
              srv_in_reg     <= 1'b1;
              sense_sent_reg <= 1'b1;
              bus_in_reg     <= {ccuif_par(sense_byte), sense_byte};
              state_reg      <= S_DATA;
            end
            else if (is_read && fifo_cnt_reg != 2'd0)
            begin
              srv_in_reg <= 1'b1;
              bus_in_reg <= {ccuif_par(fifo_mem[fifo_rp_reg]), fifo_mem[fifo_rp_reg]};
              state_reg  <= S_DATA;
            end
            else if (!is_read && !wr_valid_reg)
            begin
              srv_in_reg <= 1'b1;
              state_reg  <= S_DATA;
            end
          end
          S_DATA:
          begin
            if (srv_out || cmd_out)
            begin
              srv_in_reg <= 1'b0;
              stop_reg   <= cmd_out;
              state_reg  <= S_DATA_DROP;
            end
          end
          S_DATA_DROP:
          begin
            if (!srv_out && !cmd_out)
              state_reg <= S_XFER;
          end
          S_REL:
          begin
            op_in_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  parity_odd_a: assert property (bus_in_reg[PAR_POS] == ccuif_par(bus_in_reg[7:0]))
    else $error("inbound parity is not odd");
  hold_purge_a: assert property ($fell(hold_out) |=> !sel_fwd_reg)
    else $error("forwarded select survived hold-out fall");
  op_reset_a: assert property (!op_out |=> !op_in_reg && !srv_in_reg && !sta_in_reg && !req_in_reg)
    else $error("in lines active without operational-out");
  srv_interlock_a: assert property (srv_in_reg && !srv_out && !cmd_out && op_out && !disc_seen |=> srv_in_reg)
    else $error("service-in dropped before acknowledge");
  decode_write_a: assert property (cmd_strobe_reg && cmd_byte_reg[1:0] == CMD_LO2_WRITE
                                   |-> cmd_kind_reg == CK_WRITE)
    else $error("write command misdecoded");
  decode_rdbk_a: assert property (cmd_strobe_reg && cmd_byte_reg[3:0] == CMD_LO4_RDBK && cmd_byte_reg != CMD_TEST
                                  |-> cmd_kind_reg == CK_RDBK)
    else $error("read-backward misdecoded");
  decode_test_a: assert property (cmd_strobe_reg && cmd_byte_reg == CMD_TEST |-> cmd_kind_reg == CK_TEST)
    else $error("test-status misdecoded");
  ctrl_noop_a: assert property (cmd_strobe_reg && cmd_byte_reg == 8'h03 |-> ##1 1'b1 ##[1:300]
                                (sta_in_reg && bus_in_reg[7:0] == STAT_END) or !op_out or cmd_out)
    else $error("no-operation did not end at once");
  sel_block_a: assert property (state_reg != S_IDLE |=> !sel_fwd_reg)
    else $error("select forwarded while connected");
  sel_pass_a: assert property (state_reg == S_IDLE && op_out && sel_out && hold_out && !claim_iss && !claim_poll
                               |=> sel_fwd_reg)
    else $error("select not passed on");
  addr_block_a: assert property ($rose(op_in_reg) && !cui_reg |-> $past(addr_hit))
    else $error("answered an address outside the block");

  write_cv: cover property (state_reg == S_DATA && srv_out && cmd_kind_reg == CK_WRITE);
  read_cv: cover property (fifo_pop && cmd_kind_reg == CK_READ);
  poll_cv: cover property ($rose(op_in_reg) && cui_reg);
  disc_cv: cover property (disc_seen);

endmodule

`default_nettype wire

// file: sim/ccuif_chan_model.sv
// channel side model: drives the out lines and follows the in tags of one unit
`timescale 1ns/1ps
`default_nettype none
module ccuif_chan_model
  import ccuif_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             op_in,
  input  wire logic             addr_in,
  input  wire logic             sta_in,
  input  wire logic             srv_in,
  input  wire logic [BUS_W-1:0] bus_in,
  output logic [BUS_W-1:0]      bus_out,
  output logic                  op_out,
  output logic                  hold_out,
  output logic                  sel_out,
  output logic                  supp_out,
  output logic                  addr_out,
  output logic                  cmd_out,
  output logic                  srv_out
);
  int               miss = 0;
  int               cc   = 0;
  logic [BUS_W-1:0] last_in;
  // all out lines low until the bench starts
  initial
  begin
    {op_out, hold_out, sel_out, supp_out, addr_out, cmd_out, srv_out} = 7'h00;
    bus_out = 9'h000;
  end
  // in tag by index: 0 operational, 1 address, 2 status, 3 service
  function automatic logic tg(input int i);
    case (i)
      0: tg = op_in;
      1: tg = addr_in;
      2: tg = sta_in;
      default: tg = srv_in;
    endcase
  endfunction
  // wait for a tag level at a rising edge, take the bus there, move on at the fall
  task automatic wt(input int i, input logic v, input int lim = 20);
    bit ok;
    ok = 0;
    for (int n = 0; n < lim && !ok; n++)
    begin
      @(posedge clk);
      ok = (tg(i) === v);
      last_in = bus_in;
    end
    if (!ok) miss++;
    @(negedge clk);
  endtask
  // byte with odd parity, optionally spoilt
  task automatic put(input logic [7:0] d, input bit bad);
    bus_out = {~(^d) ^ bad, d};
  endtask
  // operational and hold levels; dropping operational drops select too
  task automatic set_oh(input logic op, input logic ho);
    op_out = op;
    hold_out = ho;
    if (!op) sel_out = 0;
    @(negedge clk);
  endtask
  // address on the bus first, then select; without address this is a poll
  task automatic sel(input logic [7:0] a, input bit adr, output bit got);
    if (adr) put(a, 0);
    else bus_out = ~bus_out;
    addr_out = adr;
    @(negedge clk);
    {sel_out, hold_out} = 2'b11;
    got = 0;
    repeat (6)
    begin
      @(posedge clk);
      got |= (op_in === 1'b1);
    end
    @(negedge clk);
    cc = got ? 0 : 3;
  endtask
  // take a status byte and accept it
  task automatic endst(output logic [BUS_W-1:0] st);
    wt(2, 1);
    st = last_in;
    srv_out = 1;
    wt(2, 0);
    srv_out = 0;
    cc = (st[7:0] != 8'h00) ? 1 : 0;
  endtask
  // address echo, command byte, initial status
  task automatic cmd(input logic [7:0] c, input bit bad, output logic [BUS_W-1:0] ad,
                     output logic [BUS_W-1:0] st);
    addr_out = 0;
    wt(1, 1);
    ad = last_in;
    put(c, bad);
    cmd_out = 1;
    wt(1, 0);
    cmd_out = 0;
    bus_out = ~bus_out;
    endst(st);
  endtask
  // take one inbound byte, acknowledging after a stall
  task automatic rx(output logic [BUS_W-1:0] d, input int stall);
    wt(3, 1);
    d = last_in;
    repeat (stall) @(negedge clk);
    srv_out = 1;
    wt(3, 0);
    srv_out = 0;
  endtask
  // hand one outbound byte when asked
  task automatic tx(input logic [7:0] d, input bit bad);
    wt(3, 1);
    put(d, bad);
    srv_out = 1;
    wt(3, 0);
    srv_out = 0;
    bus_out = ~bus_out;
  endtask
  // drop select; with d set, follow with interface disconnect
  task automatic disc(input bit d);
    {sel_out, hold_out} = 2'b00;
    if (d)
    begin
      @(negedge clk);
      addr_out = 1;
    end
    wt(0, 0, d ? 3 : 20);
    addr_out = 0;
    cc = d ? 2 : 0;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the channel control unit interface
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccuif_pkg::*;
;
  logic             sys_clk = 0, rst_n = 0, need_service = 0, status_event = 0;
  logic             dev_done = 0, rd_valid = 0, wr_ready = 0, full = 0;
  bit               got;
  logic [7:0]       svc_addr = 8'h00, sense_byte = 8'h00, status_byte = 8'h00, rd_data = 8'h00, b8;
  logic [7:0]       cfg_base = 8'h40, cfg_mask = 8'hF0;
  logic [BUS_W-1:0] bus_out, bus_in_reg, st, ad, b;
  logic             op_out, hold_out, sel_out, supp_out, addr_out, cmd_out, srv_out;
  logic             op_in_reg, sel_fwd_reg, req_in_reg, addr_in_reg, sta_in_reg, srv_in_reg;
  logic             rd_ready_reg, wr_valid_reg, cmd_strobe_reg, par_err_reg;
  logic [7:0]       wr_data_reg, cmd_byte_reg, k_byte;
  ccuif_cmd_e       cmd_kind_reg, k_kind;
  logic [7:0]       cl [10] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h07, 8'h0C, 8'h04, 8'h08, 8'h00, 8'h00};
  logic [7:0]       rq [$], wq [$];
  int               error_cnt = 0, compares = 0;
  // design and channel model
  ccuif_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_out(bus_out), .op_out(op_out), .hold_out(hold_out),
    .sel_out(sel_out), .supp_out(supp_out), .addr_out(addr_out), .cmd_out(cmd_out), .srv_out(srv_out),
    .bus_in_reg(bus_in_reg), .op_in_reg(op_in_reg), .sel_fwd_reg(sel_fwd_reg), .req_in_reg(req_in_reg),
    .addr_in_reg(addr_in_reg), .sta_in_reg(sta_in_reg), .srv_in_reg(srv_in_reg), .cfg_base(cfg_base),
    .cfg_mask(cfg_mask), .svc_addr(svc_addr), .need_service(need_service), .status_event(status_event),
    .status_byte(status_byte), .sense_byte(sense_byte), .dev_done(dev_done), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ready_reg(rd_ready_reg), .wr_data_reg(wr_data_reg), .wr_valid_reg(wr_valid_reg),
    .wr_ready(wr_ready), .cmd_strobe_reg(cmd_strobe_reg), .cmd_byte_reg(cmd_byte_reg),
    .cmd_kind_reg(cmd_kind_reg), .par_err_reg(par_err_reg));
  ccuif_chan_model ch (.clk(sys_clk), .op_in(op_in_reg), .addr_in(addr_in_reg), .sta_in(sta_in_reg),
    .srv_in(srv_in_reg), .bus_in(bus_in_reg), .bus_out(bus_out), .op_out(op_out), .hold_out(hold_out),
    .sel_out(sel_out), .supp_out(supp_out), .addr_out(addr_out), .cmd_out(cmd_out), .srv_out(srv_out));
  // clock at 100 MHz
  initial forever #5 sys_clk = ~sys_clk;
  // compare one value and count it
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // reference bus value with odd parity
  function automatic logic [8:0] pw(input logic [7:0] d);
    pw = {~(^d), d};
  endfunction
  // reference command classification
  function automatic ccuif_cmd_e mk(input int c);
    if (c == 0) mk = CK_TEST;
    else if (c % 16 == 12) mk = CK_RDBK;
    else if (c % 16 == 4) mk = CK_SENSE;
    else if (c % 4 == 2) mk = CK_READ;
    else if (c % 4 == 1) mk = CK_WRITE;
    else if (c % 4 == 3) mk = (c < 4) ? CK_NOOP : CK_CTRL;
    else mk = CK_BAD;
  endfunction
  // offer one inbound byte, noting any refusal
  task automatic push(input logic [7:0] d);
    rd_data = d;
    rd_valid = 1;
    rq.push_back(d);
    for (int n = 0; n < 30; n++)
    begin
      @(posedge sys_clk);
      if (rd_ready_reg === 1'b1) break;
      full = 1;
    end
    @(negedge sys_clk);
  endtask
  // latch each command strobe; random write sink checked against the queue
  always @(posedge sys_clk)
    if (cmd_strobe_reg === 1'b1)
    begin
      k_byte <= cmd_byte_reg;
      k_kind <= cmd_kind_reg;
    end
  always @(negedge sys_clk) wr_ready <= 1'($urandom_range(0, 1));
  always @(posedge sys_clk)
    if (wr_valid_reg === 1'b1 && wr_ready === 1'b1) chk("wr", wr_data_reg, wq.pop_front());
  // verdict and end of run
  task automatic end_of_test();
    chk("chan", ch.miss, 0);
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100us;
    error_cnt++;
    $display("timeout");
    end_of_test();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h4c85));
    svc_addr = 8'($urandom);
    sense_byte = 8'($urandom);
    {cl[8], cl[9]} = 16'($urandom);
    repeat (10) @(negedge sys_clk);
    rst_n = 1;
    repeat (3) @(negedge sys_clk);
    chk("rst", {op_in_reg, bus_in_reg}, 10'h100);
    ch.set_oh(1, 0);
    foreach (cl[i])
    begin
      ch.sel({4'h4, 4'(i)}, 1, got);
      chk("claim", got, 1);
      ch.cmd(cl[i], 0, ad, st);
      chk("echo", ad, pw({4'h4, 4'(i)}));
      chk("kind", k_kind, mk(cl[i]));
      chk("cbyte", k_byte, cl[i]);
      chk("stat", st, pw(mk(cl[i]) == CK_BAD ? STAT_CHECK
                         : (mk(cl[i]) inside {CK_TEST, CK_NOOP}) ? STAT_END : STAT_ACCEPT));
      if (mk(cl[i]) == CK_SENSE) ch.rx(b, 0);
      if (mk(cl[i]) == CK_SENSE) chk("sense", b, pw(sense_byte));
      ch.disc(1);
      chk("disc", {op_in_reg, addr_in_reg, sta_in_reg, srv_in_reg}, 0);
    end
    $display("test decode done");
    cfg_base = 8'h41;
    cfg_mask = 8'hFF;
    status_byte = 8'($urandom_range(1, 255));
    status_event = 1;
    @(negedge sys_clk);
    status_event = 0;
    for (int j = 0; j < 2; j++)
    begin
      ch.sel(8'h41, 1, got);
      ch.cmd(CMD_TEST, 0, ad, st);
      chk("tstat", st, pw(j == 0 ? status_byte : STAT_END));
      ch.disc(1);
    end
    $display("test status done");
    ch.sel(8'h50, 1, got);
    chk("miss", {got, sel_fwd_reg}, 2'b01);
    ch.set_oh(1, 0);
    chk("hold", sel_fwd_reg, 0);
    ch.disc(1);
    cfg_base = 8'h40;
    cfg_mask = 8'hF0;
    need_service = 1;
    repeat (2) @(negedge sys_clk);
    chk("req", req_in_reg, 1);
    ch.sel(8'h00, 0, got);
    chk("ui", {op_in_reg, addr_in_reg, sel_fwd_reg}, 3'b110);
    need_service = 0;
    ch.cmd(8'h00, 0, ad, st);
    chk("svc", ad, pw(svc_addr));
    chk("ust", st, pw(STAT_END));
    ch.disc(0);
    $display("test select done");
    ch.sel(8'h42, 1, got);
    ch.cmd(8'h02, 0, ad, st);
    fork
      begin
        for (int j = 0; j < 4; j++) push(8'($urandom));
        rd_valid = 0; // no repeat of the last byte
      end
      for (int j = 0; j < 4; j++)
      begin
        ch.rx(b, j == 0 ? 6 : j);
        chk("rd", b, pw(rq.pop_front()));
      end
    join
    chk("full", full, 1);
    chk("perr0", par_err_reg, 0);
    dev_done = 1;
    ch.endst(st);
    chk("rend", st, pw(STAT_END));
    dev_done = 0;
    ch.disc(0);
    $display("test read done");
    ch.sel(8'h43, 1, got);
    ch.cmd(8'h01, 0, ad, st);
    for (int j = 0; j < 3; j++)
    begin
      b8 = 8'($urandom);
      wq.push_back(b8);
      ch.tx(b8, j == 2);
    end
    repeat (20) if (wq.size() != 0) @(negedge sys_clk);
    chk("wq", wq.size(), 0);
    chk("perr", par_err_reg, 1);
    ch.set_oh(0, 0);
    @(negedge sys_clk);
    chk("opoff", {op_in_reg, addr_in_reg, sta_in_reg, srv_in_reg, par_err_reg}, 0);
    $display("test write done");
    end_of_test();
  end
endmodule
`default_nettype wire
